// File: hw/tpg_bridge.sv
// One half-bridge: PWM mode, dead time and overcurrent response.
`timescale 1ns/1ps
`default_nettype none
module tpg_bridge (
  // Clock and reset.
  input wire logic CORE_CLK,
  input wire logic SRST,
  // Bridge signals.
  tpg_bridge_if.leg br
);
  import tpg_pkg::*;

  tpg_phase_e st_ff;
  tpg_phase_e nxt_st;
  logic [3:0] cnt_ff;
  logic [3:0] nxt_cnt;
  logic       latch_ff;
  logic       nxt_latch;
  logic       want_h;
  logic       want_l;
  logic       tgt_h;

  // Requested sides; in three-input mode low is the complement of high.
  always_comb begin
    want_h = br.hs_req;
    want_l = br.complement ? ~br.hs_req : br.ls_req;
  end

  // Next state: dead-time sequencing and overcurrent blocking.
  always_comb begin
    nxt_st    = st_ff;
    nxt_cnt   = cnt_ff;
    tgt_h     = want_h;
    nxt_latch = latch_ff;
    if (br.oc_trip && br.oc_latch_mode) begin
      nxt_latch = 1'b1;
    end else if (br.oc_clear) begin
      nxt_latch = 1'b0;
    end
    if (!br.enable || br.oc_trip || latch_ff) begin
      // Trip cuts this cycle only when limiting, holds off when latching.
      nxt_st  = TPG_OFF;
      nxt_cnt = DEAD_CNT;
    end else if (!br.complement) begin
      nxt_st  = (want_h && !want_l) ? TPG_HIGH : (want_l && !want_h) ? TPG_LOW : TPG_OFF;
      // Keep the gap armed so that a switch into three-input mode starts with a gap.
      nxt_cnt = DEAD_CNT;
    end else begin
      case (st_ff)
        TPG_OFF, TPG_GAP: begin
          if (cnt_ff != 4'h0) begin
            nxt_cnt = cnt_ff - 4'h1;
            nxt_st  = TPG_GAP;
          end else begin
            nxt_st = tgt_h ? TPG_HIGH : TPG_LOW;
          end
        end
        TPG_HIGH: begin
          if (!tgt_h) begin
            nxt_st  = TPG_GAP;
            nxt_cnt = DEAD_CNT;
          end
        end
        TPG_LOW: begin
          if (tgt_h) begin
            nxt_st  = TPG_GAP;
            nxt_cnt = DEAD_CNT;
          end
        end
        default: nxt_st = TPG_OFF;
      endcase
    end
  end

  // State registers.
  always_ff @(posedge CORE_CLK) begin
    if (SRST) begin
      st_ff    <= TPG_OFF;
      cnt_ff   <= DEAD_CNT;
      latch_ff <= 1'b0;
    end else begin
      st_ff    <= nxt_st;
      cnt_ff   <= nxt_cnt;
      latch_ff <= nxt_latch;
    end
  end

  assign br.hs_drv     = (st_ff == TPG_HIGH);
  assign br.ls_drv     = (st_ff == TPG_LOW);
  assign br.oc_latched = latch_ff;

  // Three-input mode: one side is never followed straight by the other.
  a_no_shoot_through: assert property (@(posedge CORE_CLK) disable iff (SRST)
    br.complement && br.hs_drv |=> !br.ls_drv) else $error("low side follows high side directly");
  a_no_low_to_high: assert property (@(posedge CORE_CLK) disable iff (SRST)
    br.complement && br.ls_drv |=> !br.hs_drv) else $error("high side follows low side directly");
  a_gap_after_high: assert property (@(posedge CORE_CLK) disable iff (SRST)
    $past(br.complement) && br.complement && $fell(br.hs_drv) |-> !br.ls_drv[*4])
    else $error("gap too short");
  a_latch_holds: assert property (@(posedge CORE_CLK) disable iff (SRST)
    latch_ff && !br.oc_clear |=> latch_ff && !br.hs_drv && !br.ls_drv) else $error("latch lost");
  a_limit_no_latch: assert property (@(posedge CORE_CLK) disable iff (SRST)
    br.oc_trip && !br.oc_latch_mode && !latch_ff |=> !latch_ff && !br.hs_drv) else $error("cycle limit wrong");
  c_gap_seen: cover property (@(posedge CORE_CLK) st_ff == TPG_GAP ##4 st_ff == TPG_LOW);
  c_latch_seen: cover property (@(posedge CORE_CLK) $rose(latch_ff));
endmodule
`default_nettype wire

// File: hw/tpg_bridge_if.sv
// Interface carrying one half-bridge's requests and drives.
`timescale 1ns/1ps
`default_nettype none
interface tpg_bridge_if;
  logic hs_req;
  logic ls_req;
  logic complement;
  logic enable;
  logic oc_trip;
  logic oc_latch_mode;
  logic oc_clear;
  logic hs_drv;
  logic ls_drv;
  logic oc_latched;
  modport ctl (output hs_req, ls_req, complement, enable, oc_trip, oc_latch_mode, oc_clear,
               input hs_drv, ls_drv, oc_latched);
  modport leg (input hs_req, ls_req, complement, enable, oc_trip, oc_latch_mode, oc_clear,
               output hs_drv, ls_drv, oc_latched);
endinterface
`default_nettype wire

// File: hw/tpg_ctrl.sv
// Top of the three-phase gate control: APB registers, modes, flags and drives.
// How it works
// - Mode low: six PWM inputs each steer their own gate; a bridge with both inputs high stays off.
// - Mode high: host drives high sides only; low sides are their complements.
// - Overcurrent mode low: trip cuts the bridge for that cycle only.
// - Overcurrent mode high: only the tripped bridge latches off.
// - Gain select low gives 10 V/V, high gives 40 V/V on both amplifiers.
// - Calibrate high shorts amplifier inputs and disconnects their loads.
// - Gate enable gates drivers and amplifiers; buck has its own enable.
// - Overcurrent and overtemperature warnings pull the open-drain warning output low.
// - Faults pull a separate open-drain fault output low.
// - Power-good goes low on thermal shutdown, dropout, overvoltage or buck disable.
//
// The APB interface to the registers and the address map were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module tpg_ctrl (
  // Clock and reset.
  input  wire logic       CORE_CLK,
  input  wire logic       SRST,
  // APB slave.
  input  wire logic       PSEL,
  input  wire logic       PENABLE,
  input  wire logic       PWRITE,
  input  wire logic [7:0] PADDR,
  input  wire logic [31:0] PWDATA,
  output logic            PREADY,
  output logic [31:0]     PRDATA,
  output logic            PSLVERR,
  // PWM inputs.
  input  wire logic       HIGH_SIDE_PWM_IN_A,
  input  wire logic       LOW_SIDE_PWM_IN_A,
  input  wire logic       HIGH_SIDE_PWM_IN_B,
  input  wire logic       LOW_SIDE_PWM_IN_B,
  input  wire logic       HIGH_SIDE_PWM_IN_C,
  input  wire logic       LOW_SIDE_PWM_IN_C,
  // Power stage sensing.
  input  wire logic [2:0] OC_DETECT,
  input  wire logic       OVERTEMP_WARN,
  input  wire logic       FAULT_DETECT,
  input  wire logic       BUCK_THERMAL_SHUTDOWN,
  input  wire logic       BUCK_DROPOUT,
  input  wire logic       BUCK_OVERVOLTAGE,
  // Gate drives.
  output logic [2:0]      GATE_HIGH,
  output logic [2:0]      GATE_LOW,
  // Amplifier and regulator controls.
  output logic [5:0]      AMP_GAIN_VV,
  output logic            AMP_ENABLE,
  output logic            AMP_INPUT_SHORT,
  output logic            AMP_LOAD_DISCONNECT,
  output logic            BUCK_ENABLE,
  // Open-drain flags; pin is low while the enable is high.
  output logic            WARNING_FLAG_N_O,
  output logic            WARNING_FLAG_N_OE,
  output logic            FAULT_FLAG_N_O,
  output logic            FAULT_FLAG_N_OE,
  output logic            REGULATOR_POWER_GOOD_O,
  output logic            REGULATOR_POWER_GOOD_OE
);
  import tpg_pkg::*;

  // ==========================================================================
  // Register state
  // ==========================================================================
  logic [5:0]  ctrl_ff;
  logic [5:0]  nxt_ctrl;
  logic        pready_ff;
  logic        nxt_pready;
  logic [31:0] prdata_ff;
  logic [31:0] nxt_prdata;
  logic        pslverr_ff;
  logic        nxt_pslverr;
  logic        oc_clear;
  logic [2:0]  hs_in;
  logic [2:0]  ls_in;
  logic [2:0]  hs_drv;
  logic [2:0]  ls_drv;
  logic [2:0]  oc_latched;
  logic        setup;
  logic        done;

  // Address decode of the three mapped offsets, used only by the pslverr path.
  function automatic logic mapped(input logic [7:0] a);
    mapped = (a == CTRL_OFS) || (a == STATUS_OFS) || (a == SENSE_OFS);
  endfunction

  assign hs_in = {HIGH_SIDE_PWM_IN_C, HIGH_SIDE_PWM_IN_B, HIGH_SIDE_PWM_IN_A};
  assign ls_in = {LOW_SIDE_PWM_IN_C, LOW_SIDE_PWM_IN_B, LOW_SIDE_PWM_IN_A};
  // Answer one cycle into access; pready is low in the first access cycle.
  assign setup = PSEL && PENABLE && !pready_ff;
  // Writes land at the edge that samples pready high, so a cut transfer changes nothing.
  assign done  = PSEL && PENABLE && pready_ff;

  // APB next values: one wait cycle, then the answer with registered data.
  always_comb begin
    nxt_ctrl    = ctrl_ff;
    nxt_pready  = setup;
    nxt_prdata  = 32'h0;
    nxt_pslverr = setup && !mapped(PADDR);
    oc_clear    = 1'b0;
    if (done && PWRITE && PADDR == CTRL_OFS) begin
      nxt_ctrl = PWDATA[5:0];
    end
    // Writing ones to the status word releases latched bridges.
    if (done && PWRITE && PADDR == STATUS_OFS) begin
      oc_clear = 1'b1;
    end
    if (setup && !PWRITE) begin
      case (PADDR)
        CTRL_OFS:   nxt_prdata = {26'h0, ctrl_ff};
        STATUS_OFS: nxt_prdata = {24'h0, OVERTEMP_WARN, FAULT_DETECT, oc_latched, OC_DETECT};
        SENSE_OFS:  nxt_prdata = {26'h0, ls_drv, hs_drv};
        default:    nxt_prdata = 32'h0;
      endcase
    end
  end

  always_ff @(posedge CORE_CLK) begin
    if (SRST) begin
      ctrl_ff    <= CTRL_RST;
      pready_ff  <= 1'b0;
      prdata_ff  <= 32'h0;
      pslverr_ff <= 1'b0;
    end else begin
      ctrl_ff    <= nxt_ctrl;
      pready_ff  <= nxt_pready;
      prdata_ff  <= nxt_prdata;
      pslverr_ff <= nxt_pslverr;
    end
  end

  assign PREADY  = pready_ff;
  assign PRDATA  = prdata_ff;
  assign PSLVERR = pslverr_ff;

  // ==========================================================================
  // Half-bridges
  // ==========================================================================
  genvar g;
  generate
    for (g = 0; g < 3; g++) begin : g_leg
      tpg_bridge_if bif ();
      assign bif.hs_req        = hs_in[g];
      assign bif.ls_req        = ls_in[g];
      assign bif.complement    = ctrl_ff[CTRL_PWM_MODE_BIT];
      assign bif.enable        = ctrl_ff[CTRL_GATE_EN_BIT];
      assign bif.oc_trip       = OC_DETECT[g];
      assign bif.oc_latch_mode = ctrl_ff[CTRL_OC_MODE_BIT];
      assign bif.oc_clear      = oc_clear && PWDATA[3+g];
      assign hs_drv[g]         = bif.hs_drv;
      assign ls_drv[g]         = bif.ls_drv;
      assign oc_latched[g]     = bif.oc_latched;
      tpg_bridge u_leg (
        .CORE_CLK (CORE_CLK),
        .SRST     (SRST),
        .br       (bif.leg)
      );
    end
  endgenerate

  // ==========================================================================
  // Registered pin outputs
  // ==========================================================================
  logic [2:0] gh_ff;
  logic [2:0] gl_ff;
  logic [5:0] gain_ff;
  logic       amp_en_ff;
  logic       short_ff;
  logic       buck_en_ff;
  logic       warn_ff;
  logic       fault_ff;
  logic       pgood_low_ff;
  logic [2:0] nxt_gh;
  logic [2:0] nxt_gl;
  logic [5:0] nxt_gain;
  logic       nxt_amp_en;
  logic       nxt_short;
  logic       nxt_buck_en;
  logic       nxt_warn;
  logic       nxt_fault;
  logic       nxt_pgood_low;

  // Pin values; one register stage adds a cycle of latency to every drive.
  always_comb begin
    nxt_gh        = hs_drv;
    nxt_gl        = ls_drv;
    nxt_gain      = ctrl_ff[CTRL_GAIN_BIT] ? GAIN_HIGH_VV : GAIN_LOW_VV;
    nxt_amp_en    = ctrl_ff[CTRL_GATE_EN_BIT];
    nxt_short     = ctrl_ff[CTRL_CAL_BIT];
    nxt_buck_en   = ctrl_ff[CTRL_BUCK_EN_BIT];
    nxt_warn      = (|OC_DETECT) || OVERTEMP_WARN;
    nxt_fault     = FAULT_DETECT || (|oc_latched);
    nxt_pgood_low = BUCK_THERMAL_SHUTDOWN || BUCK_DROPOUT || BUCK_OVERVOLTAGE
                    || !ctrl_ff[CTRL_BUCK_EN_BIT];
  end

  always_ff @(posedge CORE_CLK) begin
    if (SRST) begin
      gh_ff        <= 3'h0;
      gl_ff        <= 3'h0;
      gain_ff      <= GAIN_LOW_VV;
      amp_en_ff    <= 1'b0;
      short_ff     <= 1'b0;
      buck_en_ff   <= 1'b1;
      warn_ff      <= 1'b0;
      fault_ff     <= 1'b0;
      pgood_low_ff <= 1'b1;
    end else begin
      gh_ff        <= nxt_gh;
      gl_ff        <= nxt_gl;
      gain_ff      <= nxt_gain;
      amp_en_ff    <= nxt_amp_en;
      short_ff     <= nxt_short;
      buck_en_ff   <= nxt_buck_en;
      warn_ff      <= nxt_warn;
      fault_ff     <= nxt_fault;
      pgood_low_ff <= nxt_pgood_low;
    end
  end

  assign GATE_HIGH               = gh_ff;
  assign GATE_LOW                = gl_ff;
  assign AMP_GAIN_VV             = gain_ff;
  assign AMP_ENABLE              = amp_en_ff;
  assign AMP_INPUT_SHORT         = short_ff;
  assign AMP_LOAD_DISCONNECT     = short_ff;
  assign BUCK_ENABLE             = buck_en_ff;
  assign WARNING_FLAG_N_O        = 1'b0;
  assign WARNING_FLAG_N_OE       = warn_ff;
  assign FAULT_FLAG_N_O          = 1'b0;
  assign FAULT_FLAG_N_OE         = fault_ff;
  assign REGULATOR_POWER_GOOD_O  = 1'b0;
  assign REGULATOR_POWER_GOOD_OE = pgood_low_ff;

  // ==========================================================================
  // Checks
  // ==========================================================================
  // Gate pins: a drive is two edges behind its request; a three-input turn-on also waits out the dead-time gap.
  a_six_input_follow: assert property (
    @(posedge CORE_CLK) disable iff (SRST)
    !ctrl_ff[CTRL_PWM_MODE_BIT] && ctrl_ff[CTRL_GATE_EN_BIT] && OC_DETECT == 3'h0 && oc_latched == 3'h0
    && HIGH_SIDE_PWM_IN_A && !LOW_SIDE_PWM_IN_A ##1 !ctrl_ff[CTRL_PWM_MODE_BIT]
    |=> GATE_HIGH[0])
    else $error("gate A high not following input");
  a_complement_low: assert property (
    @(posedge CORE_CLK) disable iff (SRST)
    GATE_LOW[0] && $past(ctrl_ff[CTRL_PWM_MODE_BIT], 2)
    |-> !$past(HIGH_SIDE_PWM_IN_A, 2))
    else $error("low side not complement");
  a_gate_disable: assert property (
    @(posedge CORE_CLK) disable iff (SRST)
    !ctrl_ff[CTRL_GATE_EN_BIT] ##1 !ctrl_ff[CTRL_GATE_EN_BIT]
    |=> GATE_HIGH == 3'h0 && !AMP_ENABLE)
    else $error("gate enable ignored");

  // Amplifier and regulator controls follow their control bits one edge later.
  a_gain_select: assert property (
    @(posedge CORE_CLK) disable iff (SRST)
    AMP_GAIN_VV == ($past(ctrl_ff[CTRL_GAIN_BIT]) ? GAIN_HIGH_VV : GAIN_LOW_VV))
    else $error("gain not as selected");
  a_cal_short: assert property (
    @(posedge CORE_CLK) disable iff (SRST)
    $rose(ctrl_ff[CTRL_CAL_BIT]) |=> AMP_INPUT_SHORT && AMP_LOAD_DISCONNECT)
    else $error("cal not applied");
  a_cal_release: assert property (
    @(posedge CORE_CLK) disable iff (SRST)
    $fell(ctrl_ff[CTRL_CAL_BIT]) |=> !AMP_INPUT_SHORT && !AMP_LOAD_DISCONNECT)
    else $error("cal not released");
  a_enable_split: assert property (
    @(posedge CORE_CLK) disable iff (SRST)
    AMP_ENABLE == $past(ctrl_ff[CTRL_GATE_EN_BIT]) && BUCK_ENABLE == $past(ctrl_ff[CTRL_BUCK_EN_BIT]))
    else $error("enables not kept apart");

  // Open-drain flags: the enable pulls the line low one edge after its cause.
  a_warn_flag: assert property (
    @(posedge CORE_CLK) disable iff (SRST)
    OVERTEMP_WARN |=> WARNING_FLAG_N_OE && !WARNING_FLAG_N_O)
    else $error("warning not low");
  a_fault_flag: assert property (
    @(posedge CORE_CLK) disable iff (SRST)
    FAULT_DETECT |=> FAULT_FLAG_N_OE)
    else $error("fault not low");
  a_pgood_low: assert property (
    @(posedge CORE_CLK) disable iff (SRST)
    BUCK_DROPOUT || !ctrl_ff[CTRL_BUCK_EN_BIT] |=> REGULATOR_POWER_GOOD_OE)
    else $error("power good high");

  // Register bus: one wait state, and nothing is written before the answer.
  a_apb_wait: assert property (
    @(posedge CORE_CLK) disable iff (SRST)
    PSEL && !PENABLE ##1 PSEL && PENABLE |-> !PREADY ##1 PREADY)
    else $error("apb timing");
  a_write_on_ready: assert property (
    @(posedge CORE_CLK) disable iff (SRST)
    PSEL && PENABLE && !PREADY |=> ctrl_ff == $past(ctrl_ff))
    else $error("write before ready");
  a_unmapped_error: assert property (
    @(posedge CORE_CLK) disable iff (SRST)
    PSEL && PENABLE && !PREADY && !mapped(PADDR) |=> PREADY && PSLVERR)
    else $error("unmapped access not refused");
  c_write_ctrl: cover property (@(posedge CORE_CLK) PREADY && PWRITE && PADDR == CTRL_OFS);
  c_oc_latch: cover property (@(posedge CORE_CLK) FAULT_FLAG_N_OE && ctrl_ff[CTRL_OC_MODE_BIT]);
  c_three_mode: cover property (@(posedge CORE_CLK) ctrl_ff[CTRL_PWM_MODE_BIT] && GATE_LOW[1]);
endmodule
`default_nettype wire

// File: hw/tpg_pkg.sv
// Package of constants and types for the three-phase gate control logic.
package tpg_pkg;

  // ==========================================================================
  // Register map (APB byte addresses)
  // ==========================================================================
  localparam logic [7:0] CTRL_OFS   = 8'h00;
  localparam logic [7:0] STATUS_OFS = 8'h04;
  localparam logic [7:0] SENSE_OFS  = 8'h08;

  // Control register fields.
  localparam int CTRL_PWM_MODE_BIT = 0;
  localparam int CTRL_OC_MODE_BIT  = 1;
  localparam int CTRL_GAIN_BIT     = 2;
  localparam int CTRL_CAL_BIT      = 3;
  localparam int CTRL_GATE_EN_BIT  = 4;
  localparam int CTRL_BUCK_EN_BIT  = 5;
  localparam logic [5:0] CTRL_RST  = 6'h20;

  // ==========================================================================
  // Gain codes and timing
  // ==========================================================================
  localparam logic [5:0] GAIN_LOW_VV  = 6'h0a;
  localparam logic [5:0] GAIN_HIGH_VV = 6'h28;
  localparam int CLK_MHZ     = 20;
  localparam int DEAD_NS     = 200;
  localparam int DEAD_CYC    = (DEAD_NS * CLK_MHZ + 999) / 1000;
  localparam logic [3:0] DEAD_CNT = 4'(DEAD_CYC);

  // Per-bridge dead-time states.
  typedef enum logic [1:0] {
    TPG_OFF  = 2'b00,
    TPG_GAP  = 2'b01,
    TPG_HIGH = 2'b10,
    TPG_LOW  = 2'b11
  } tpg_phase_e;

endpackage

// File: testbench/tpg_ctrl_test.sv
// Self-checking testbench of the three-phase gate control block.
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin mismatches++; \
  $display("wrong value at %0t: got %0h expected %0h", $time, (g), (e)); end end
module tpg_ctrl_test;
  import tpg_pkg::*;
  // ==========================================================================
  // Signals
  // ==========================================================================
  localparam logic [31:0] GE = 32'h1 << CTRL_GATE_EN_BIT;
  localparam logic [31:0] BK = 32'h1 << CTRL_BUCK_EN_BIT;
  localparam logic [31:0] M3 = 32'h1 << CTRL_PWM_MODE_BIT;
  localparam logic [31:0] OL = 32'h1 << CTRL_OC_MODE_BIT;
  localparam logic [31:0] GN = 32'h1 << CTRL_GAIN_BIT;
  localparam logic [31:0] CL = 32'h1 << CTRL_CAL_BIT;
  logic clk = 1'b0, srst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata;
  logic pready, pslverr, three_mode = 1'b0;
  logic [2:0] hs_cmd = 3'h0, ls_cmd = 3'h0, hs_pin, ls_pin, oc = 3'h0, gate_high, gate_low;
  logic otw = 1'b0, flt = 1'b0, bts = 1'b0, bdrop = 1'b0, bov = 1'b0;
  logic [5:0] amp_gain;
  logic amp_en, amp_short, amp_disc, buck_en, warn_oe, fault_oe, pgood_oe, warn_n, fault_n, pgood;
  int mismatches = 0, check_count = 0, cycles = 0;

  // 20 MHz clock; a hang is cut off at 20000 cycles, well past the expected couple of hundred cycles.
  always #25 clk = ~clk;
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      mismatches++;
      summarize();
    end
  end

  tpg_host_model u_host (.clk(clk), .three_mode(three_mode), .hs_cmd(hs_cmd), .ls_cmd(ls_cmd),
    .warn_oe(warn_oe), .fault_oe(fault_oe), .pgood_oe(pgood_oe), .hs_pin(hs_pin), .ls_pin(ls_pin),
    .warn_n(warn_n), .fault_n(fault_n), .pgood(pgood));

  tpg_ctrl u_dut (.CORE_CLK(clk), .SRST(srst), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
    .PADDR(paddr), .PWDATA(pwdata), .PREADY(pready), .PRDATA(prdata), .PSLVERR(pslverr),
    .HIGH_SIDE_PWM_IN_A(hs_pin[0]), .LOW_SIDE_PWM_IN_A(ls_pin[0]), .HIGH_SIDE_PWM_IN_B(hs_pin[1]),
    .LOW_SIDE_PWM_IN_B(ls_pin[1]), .HIGH_SIDE_PWM_IN_C(hs_pin[2]), .LOW_SIDE_PWM_IN_C(ls_pin[2]),
    .OC_DETECT(oc), .OVERTEMP_WARN(otw), .FAULT_DETECT(flt), .BUCK_THERMAL_SHUTDOWN(bts),
    .BUCK_DROPOUT(bdrop), .BUCK_OVERVOLTAGE(bov), .GATE_HIGH(gate_high), .GATE_LOW(gate_low),
    .AMP_GAIN_VV(amp_gain), .AMP_ENABLE(amp_en), .AMP_INPUT_SHORT(amp_short),
    .AMP_LOAD_DISCONNECT(amp_disc), .BUCK_ENABLE(buck_en), .WARNING_FLAG_N_O(),
    .WARNING_FLAG_N_OE(warn_oe), .FAULT_FLAG_N_O(), .FAULT_FLAG_N_OE(fault_oe),
    .REGULATOR_POWER_GOOD_O(), .REGULATOR_POWER_GOOD_OE(pgood_oe));

  // ==========================================================================
  // Bus and helper tasks
  // ==========================================================================
  // One APB transfer; the request stands until pready is sampled high.
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                     output logic [31:0] rd, output logic err);
    @(posedge clk);
    psel <= 1'b1; pwrite <= wr; paddr <= a; pwdata <= wd; penable <= 1'b0;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic ctl(input logic [31:0] v);
    logic [31:0] d;
    logic e;
    apb(1'b1, CTRL_OFS, v, d, e);
    three_mode <= v[CTRL_PWM_MODE_BIT];
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask

  // ==========================================================================
  // Scenarios
  // ==========================================================================
  // Reset levels, and a write to an unmapped place that must leave control alone.
  task automatic t_reset();
    logic [31:0] d;
    logic e;
    `CHK({gate_high, gate_low, amp_en, buck_en}, 8'h01);
    `CHK(amp_gain, GAIN_LOW_VV);
    apb(1'b1, 8'h0c, 32'h0, d, e);
    `CHK(e, 1'b1);
    apb(1'b0, CTRL_OFS, 32'h0, d, e);
    `CHK(d, {26'h0, CTRL_RST});
    `CHK(e, 1'b0);
  endtask

  // Six inputs, a both-high bridge refused, then the two enables kept apart.
  task automatic t_six();
    logic [31:0] d;
    logic e;
    ctl(GE | BK);
    hs_cmd <= 3'b101;
    ls_cmd <= 3'b110;
    cyc(8);
    `CHK({gate_high, gate_low}, 6'b001_010);
    `CHK(amp_en, 1'b1);
    apb(1'b0, SENSE_OFS, 32'h0, d, e);
    `CHK(d[5:0], 6'b010_001);
    ctl(BK);
    cyc(4);
    `CHK({gate_high, gate_low, amp_en, buck_en}, 8'h01);
    ctl(GE);
    cyc(4);
    `CHK({gate_high, amp_en, buck_en, pgood}, 6'b001_100);
  endtask

  // Three inputs: low sides follow the complement with a gap and never overlap.
  task automatic t_three();
    int gap = 0;
    logic both = 1'b0;
    ctl(GE | BK | M3);
    hs_cmd <= 3'b101;
    cyc(14);
    `CHK({gate_high, gate_low}, 6'b101_010);
    hs_cmd <= 3'b011;
    repeat (16) begin
      @(posedge clk);
      if ((gate_high & gate_low) !== 3'h0) both = 1'b1;
      if (gate_high[2] === 1'b0 && gate_low[2] === 1'b0) gap++;
    end
    `CHK(both, 1'b0);
    `CHK(gap >= DEAD_CYC, 1'b1);
    `CHK({gate_high, gate_low}, 6'b011_100);
  endtask

  // Every gain and calibrate combination.
  task automatic t_gain();
    for (int i = 0; i < 4; i++) begin
      ctl(GE | BK | (i[0] ? GN : 32'h0) | (i[1] ? CL : 32'h0));
      cyc(2);
      `CHK(amp_gain, i[0] ? GAIN_HIGH_VV : GAIN_LOW_VV);
      `CHK({amp_short, amp_disc}, {2{i[1]}});
    end
  endtask

  // Cycle-by-cycle limiting, then a latched trip on one bridge and its clear.
  task automatic t_oc();
    logic [31:0] d;
    logic e;
    ctl(GE | BK);
    hs_cmd <= 3'b011;
    ls_cmd <= 3'b000;
    cyc(8);
    oc <= 3'b001;
    cyc(4);
    `CHK({gate_high, warn_n}, 4'b010_0);
    oc <= 3'b000;
    cyc(6);
    `CHK(gate_high, 3'b011);
    ctl(GE | BK | OL);
    cyc(2);
    oc <= 3'b010;
    cyc(3);
    oc <= 3'b000;
    cyc(6);
    `CHK({gate_high, fault_n}, 4'b001_0);
    apb(1'b0, STATUS_OFS, 32'h0, d, e);
    `CHK(d[5:3], 3'b010);
    apb(1'b1, STATUS_OFS, 32'h10, d, e);
    cyc(6);
    `CHK({gate_high, fault_n}, 4'b011_1);
  endtask

  // Each sensed condition reaches its own flag line and no other.
  task automatic t_flags();
    for (int i = 0; i < 5; i++) begin
      {bov, bdrop, bts, flt, otw} <= 5'(1 << i);
      cyc(3);
      `CHK({pgood, fault_n, warn_n}, {i < 2, i != 1, i != 0});
    end
    {bov, bdrop, bts, flt, otw} <= 5'h0;
    cyc(3);
    `CHK({pgood, fault_n, warn_n}, 3'b111);
  endtask

  // ==========================================================================
  // Main sequence and verdict
  // ==========================================================================
  task automatic summarize();
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  initial begin
    repeat (3) @(posedge clk);
    srst <= 1'b0;
    t_reset();
    t_six();
    t_three();
    t_gain();
    t_oc();
    t_flags();
    summarize();
  end
endmodule
`default_nettype wire

// File: testbench/tpg_host_model.sv
// Host microcontroller model: PWM pin levels and pulled-up flag pins.
`timescale 1ns/1ps
`default_nettype none
module tpg_host_model (
  // Clock.
  input  wire logic       clk,
  // Commands from the scenarios.
  input  wire logic       three_mode,
  input  wire logic [2:0] hs_cmd,
  input  wire logic [2:0] ls_cmd,
  // Open-drain enables from the device.
  input  wire logic       warn_oe,
  input  wire logic       fault_oe,
  input  wire logic       pgood_oe,
  // PWM pins towards the device.
  output logic [2:0]      hs_pin,
  output logic [2:0]      ls_pin,
  // Flag levels as the host sees them.
  output logic            warn_n,
  output logic            fault_n,
  output logic            pgood
);
  // ==========================================================================
  // PWM pins
  // ==========================================================================
  // Pins start low so the device never sees an unknown level.
  initial begin
    hs_pin = 3'h0;
    ls_pin = 3'h0;
  end

  // In three-input mode the low-side pins carry no command; they toggle so that
  // a device that still listens to them shows up at once.
  always @(posedge clk) begin
    hs_pin <= hs_cmd;
    ls_pin <= three_mode ? ~ls_pin : ls_cmd;
  end

  // ==========================================================================
  // External pull-ups
  // ==========================================================================
  // Each flag line idles high and reads low only while the device pulls it.
  assign warn_n  = warn_oe ? 1'b0 : 1'b1;
  assign fault_n = fault_oe ? 1'b0 : 1'b1;
  assign pgood   = pgood_oe ? 1'b0 : 1'b1;
endmodule
`default_nettype wire
